// *** lprc_defines.svh ***
// Register map, field positions and timing constants of the low-power clock control block
`ifndef LPRC_DEFINES_SVH
`define LPRC_DEFINES_SVH

`define LPRC_ADDR_CFG 8'h00
`define LPRC_ADDR_LOADCAP 8'h01
`define LPRC_ADDR_STAT 8'h02
`define LPRC_ADDR_CTRL 8'h04
`define LPRC_ADDR_TDATA0 8'h08
`define LPRC_ADDR_TDATA3 8'h0b
`define LPRC_ADDR_ALARM0 8'h0c
`define LPRC_ADDR_ALARM3 8'h0f
`define LPRC_ADDR_IRQ_STAT 8'h10
`define LPRC_ADDR_IRQ_MASK 8'h11

`define LPRC_CTRL_EN 7
`define LPRC_CTRL_MCLK 6
`define LPRC_CTRL_FAIL 5
`define LPRC_CTRL_RUN 4
`define LPRC_CTRL_AEN 3
`define LPRC_CTRL_ALARM_FLAG_AUTORESET 2
`define LPRC_CTRL_SET 1
`define LPRC_CTRL_CAP 0

`define LPRC_IRQ_ALARM 0
`define LPRC_IRQ_FAIL 1
`define LPRC_IRQ_SET 2
`define LPRC_IRQ_CAP 3
`define LPRC_IRQ_W 4

`define LPRC_CFG_RESET 8'h00
`define LPRC_LOADCAP_RESET 8'h00

`define LPRC_XTAL_HZ 32768
`define LPRC_SELF_MIN_HZ 10000
`define LPRC_SELF_MAX_HZ 40000
`define LPRC_LFO_HZ 16400
`define LPRC_SYS_CLK_MHZ 100
`define LPRC_MISS_TIME_US 200
`define LPRC_MISS_CYCLES (`LPRC_MISS_TIME_US * `LPRC_SYS_CLK_MHZ)
`define LPRC_LOADCAP_TIME_US 100
`define LPRC_LOADCAP_CYCLES (`LPRC_LOADCAP_TIME_US * `LPRC_SYS_CLK_MHZ)
`define LPRC_VALID_EDGES 16

`endif

// *** lprc_pkg.sv ***
// Types shared by the low-power clock control modules
package lprc_pkg;

  typedef enum logic [1:0] {
    LPRC_TB_OFF,
    LPRC_TB_START,
    LPRC_TB_VALID
  } lprc_tb_state_e;

  typedef struct packed {
    logic [3:0] self_osc_trim;
    logic lfo_select;
    logic bias_double;
    logic gain_control_enable;
    logic crystal_mode_select;
  } lprc_osc_cfg_s;

  typedef struct packed {
    logic run;
    logic set_req;
    logic cap_req;
    logic alarm_en;
    logic autoreset;
  } lprc_timer_cmd_s;

  typedef struct packed {
    logic set_done;
    logic cap_done;
    logic alarm_hit;
  } lprc_timer_evt_s;

endpackage

// *** lprc_timebase.sv ***
// Timebase edge detection, clock-valid tracking and missing-clock detection
`timescale 1ns/1ps
`include "lprc_defines.svh"
module lprc_timebase #(
  parameter int MISS_CYCLES = `LPRC_MISS_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_osc_on,
  input wire logic i_lfo_select,
  input wire logic i_crystal_in_pin,
  input wire logic i_low_freq_internal_osc,
  input wire logic i_miss_en,
  output logic o_tick,
  output logic o_clock_valid,
  output logic o_missing
);
  localparam int CW = $clog2(MISS_CYCLES + 1);
  lprc_pkg::lprc_tb_state_e state_reg, state_next;
  logic sync1_reg, sync2_reg, prev_reg;
  logic [4:0] edges_reg;
  logic [CW-1:0] miss_reg;
  wire raw_clk = i_lfo_select ? i_low_freq_internal_osc : i_crystal_in_pin;
  wire miss_at_limit = (miss_reg == CW'(MISS_CYCLES - 1));
  // Timebase is slow; sampling on the system clock turns each rising edge into one tick
  assign o_tick = sync2_reg & ~prev_reg;
  assign o_missing = i_miss_en & i_osc_on & miss_at_limit & ~o_tick;
  assign o_clock_valid = (state_reg == lprc_pkg::LPRC_TB_VALID);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lprc_pkg::LPRC_TB_OFF: if (i_osc_on) state_next = lprc_pkg::LPRC_TB_START;
      lprc_pkg::LPRC_TB_START: if (o_tick && edges_reg == 5'(`LPRC_VALID_EDGES - 1)) state_next = lprc_pkg::LPRC_TB_VALID;
      lprc_pkg::LPRC_TB_VALID: if (miss_at_limit) state_next = lprc_pkg::LPRC_TB_START;
      default: state_next = lprc_pkg::LPRC_TB_OFF;
    endcase
    if (!i_osc_on) state_next = lprc_pkg::LPRC_TB_OFF;
  end

  always_ff @(posedge i_sys_clk) begin
    sync1_reg <= raw_clk;
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
    if (i_reset) begin
      state_reg <= lprc_pkg::LPRC_TB_OFF;
      edges_reg <= 5'h00;
      miss_reg <= '0;
    end else begin
      state_reg <= state_next;
      edges_reg <= (state_reg != lprc_pkg::LPRC_TB_START) ? 5'h00 : edges_reg + 5'(o_tick);
      miss_reg <= (o_tick || !i_osc_on) ? '0 : (miss_at_limit ? miss_reg : miss_reg + CW'(1));
    end
  end
endmodule

// *** lprc_timer.sv ***
// Timebase-driven timer with load, capture, alarm match and auto-reset
`timescale 1ns/1ps
module lprc_timer #(
  parameter int TIMER_W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire lprc_pkg::lprc_timer_cmd_s i_cmd,
  input wire logic [TIMER_W-1:0] i_load_value,
  input wire logic [TIMER_W-1:0] i_alarm_value,
  output logic [TIMER_W-1:0] o_capture,
  output lprc_pkg::lprc_timer_evt_s o_evt
);
  logic [TIMER_W-1:0] count_reg, count_next;
  wire alarm_match = i_cmd.alarm_en && (count_reg == i_alarm_value);
  // Load, capture and alarm only act on a timebase tick; the done pulse fires in that cycle and the result registers at its closing edge
  assign o_evt.set_done = i_tick & i_cmd.set_req;
  assign o_evt.cap_done = i_tick & i_cmd.cap_req;
  assign o_evt.alarm_hit = i_tick & alarm_match;
  assign count_next = o_evt.set_done ? i_load_value :
                      (o_evt.alarm_hit && i_cmd.autoreset) ? '0 :
                      (i_tick && i_cmd.run) ? count_reg + TIMER_W'(1) : count_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      count_reg <= '0;
      o_capture <= '0;
    end else begin
      count_reg <= count_next;
      if (o_evt.cap_done) o_capture <= count_reg;
    end
  end
endmodule

// *** lprc_rtc_ctrl.sv ***
// Top of the low-power clock control block: register port, control bits, interrupts
`timescale 1ns/1ps
`include "lprc_defines.svh"
module lprc_rtc_ctrl #(
  parameter int TIMER_W = 32,
  parameter int MISS_CYCLES = `LPRC_MISS_CYCLES,
  parameter int LOADCAP_CYCLES = `LPRC_LOADCAP_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_crystal_in_pin,
  input wire logic i_low_freq_internal_osc,
  output logic o_osc_power_enable,
  output logic o_crystal_mode_select,
  output logic o_gain_control_enable,
  output logic o_bias_double,
  output logic [7:0] o_load_cap_config,
  output logic [3:0] o_self_osc_trim,
  output logic o_low_freq_internal_osc_enable,
  output logic o_alarm_flag,
  output logic o_irq
);
  localparam int LW = $clog2(LOADCAP_CYCLES + 1);

  // Byte select of a wide word, shared by the timer and alarm windows
  function automatic logic [7:0] byte_of(input logic [TIMER_W-1:0] word, input logic [1:0] idx);
    logic [TIMER_W-1:0] shifted;
    shifted = word >> {idx, 3'b000};
    return shifted[7:0];
  endfunction

  // Byte merge of a write into a wide word
  function automatic logic [TIMER_W-1:0] merge_byte(input logic [TIMER_W-1:0] word, input logic [1:0] idx,
                                                    input logic [7:0] data);
    logic [TIMER_W-1:0] mask;
    mask = ~(TIMER_W'(8'hff) << {idx, 3'b000});
    return (word & mask) | (TIMER_W'(data) << {idx, 3'b000});
  endfunction

  lprc_pkg::lprc_osc_cfg_s cfg_reg, cfg_next;
  logic [7:0] loadcap_reg, loadcap_next;
  logic [LW-1:0] settle_reg, settle_next;
  logic osc_en_reg, osc_en_next;
  logic mclk_en_reg, mclk_en_next;
  logic fail_reg, fail_next;
  logic run_reg, run_next;
  logic aen_reg, aen_next;
  logic autoreset_reg, autoreset_next;
  logic alarm_flag_reg, alarm_flag_next;
  logic set_pend_reg, set_pend_next;
  logic cap_pend_reg, cap_pend_next;
  logic [TIMER_W-1:0] load_reg, load_next;
  logic [TIMER_W-1:0] alarm_val_reg, alarm_val_next;
  logic [`LPRC_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [`LPRC_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [7:0] rd_data_next;

  logic tick;
  logic clock_valid;
  logic missing;
  logic [TIMER_W-1:0] capture;
  lprc_pkg::lprc_timer_cmd_s cmd;
  lprc_pkg::lprc_timer_evt_s evt;

  // Address decode
  wire wr_cfg = i_wr_en && (i_addr == `LPRC_ADDR_CFG);
  wire wr_loadcap = i_wr_en && (i_addr == `LPRC_ADDR_LOADCAP);
  wire wr_ctrl = i_wr_en && (i_addr == `LPRC_ADDR_CTRL);
  wire in_tdata = (i_addr >= `LPRC_ADDR_TDATA0) && (i_addr <= `LPRC_ADDR_TDATA3);
  wire in_alarm = (i_addr >= `LPRC_ADDR_ALARM0) && (i_addr <= `LPRC_ADDR_ALARM3);
  wire wr_tdata = i_wr_en && in_tdata;
  wire wr_alarm = i_wr_en && in_alarm;
  wire wr_irq_stat = i_wr_en && (i_addr == `LPRC_ADDR_IRQ_STAT);
  wire wr_irq_mask = i_wr_en && (i_addr == `LPRC_ADDR_IRQ_MASK);
  wire [1:0] byte_idx = i_addr[1:0];

  // Control register fields as written
  wire w_en = i_wr_data[`LPRC_CTRL_EN];
  wire w_mclk = i_wr_data[`LPRC_CTRL_MCLK];
  wire w_fail = i_wr_data[`LPRC_CTRL_FAIL];
  wire w_run = i_wr_data[`LPRC_CTRL_RUN];
  wire w_aen = i_wr_data[`LPRC_CTRL_AEN];
  wire w_alarm_flag_autoreset = i_wr_data[`LPRC_CTRL_ALARM_FLAG_AUTORESET];
  wire w_set = i_wr_data[`LPRC_CTRL_SET];
  wire w_cap = i_wr_data[`LPRC_CTRL_CAP];

  // Timebase front end
  lprc_timebase #(
    .MISS_CYCLES(MISS_CYCLES)
  ) u_timebase (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_osc_on(osc_en_reg),
    .i_lfo_select(cfg_reg.lfo_select),
    .i_crystal_in_pin(i_crystal_in_pin),
    .i_low_freq_internal_osc(i_low_freq_internal_osc),
    .i_miss_en(mclk_en_reg),
    .o_tick(tick),
    .o_clock_valid(clock_valid),
    .o_missing(missing)
  );

  // Timer core; commands stay pending until the timebase tick that carries them out
  assign cmd.run = run_reg;
  assign cmd.set_req = set_pend_reg;
  assign cmd.cap_req = cap_pend_reg;
  assign cmd.alarm_en = aen_reg;
  assign cmd.autoreset = autoreset_reg;

  lprc_timer #(
    .TIMER_W(TIMER_W)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_tick(tick),
    .i_cmd(cmd),
    .i_load_value(load_reg),
    .i_alarm_value(alarm_val_reg),
    .o_capture(capture),
    .o_evt(evt)
  );

  // Oscillator configuration
  assign cfg_next = wr_cfg ? lprc_pkg::lprc_osc_cfg_s'(i_wr_data) : cfg_reg;
  assign loadcap_next = wr_loadcap ? i_wr_data : loadcap_reg;
  // Load capacitance settles over a fixed delay after each change or power-up
  assign settle_next = (wr_loadcap || !osc_en_reg) ? LW'(LOADCAP_CYCLES) :
                       (settle_reg != '0) ? settle_reg - LW'(1) : settle_reg;
  wire load_cap_ready = osc_en_reg && (settle_reg == '0);

  // Control bits
  assign osc_en_next = wr_ctrl ? w_en : osc_en_reg;
  assign mclk_en_next = wr_ctrl ? w_mclk : mclk_en_reg;
  assign run_next = wr_ctrl ? w_run : run_reg;
  assign aen_next = wr_ctrl ? w_aen : aen_reg;
  assign autoreset_next = wr_ctrl ? w_alarm_flag_autoreset : autoreset_reg;
  // Detector event wins over a clearing write in the same cycle
  assign fail_next = missing | (fail_reg & ~(wr_ctrl & ~w_fail));
  // Alarm flag lives one timebase cycle; a control write clears it unless a new hit lands
  assign alarm_flag_next = evt.alarm_hit | (alarm_flag_reg & ~tick & ~wr_ctrl);
  // Writing 0 to set or capture has no effect; a 1 during a pending operation is absorbed
  assign set_pend_next = (wr_ctrl & w_set) | (set_pend_reg & ~evt.set_done);
  assign cap_pend_next = (wr_ctrl & w_cap) | (cap_pend_reg & ~evt.cap_done);

  // Timer data windows
  assign load_next = wr_tdata ? merge_byte(load_reg, byte_idx, i_wr_data) : load_reg;
  assign alarm_val_next = wr_alarm ? merge_byte(alarm_val_reg, byte_idx, i_wr_data) : alarm_val_reg;

  // Interrupt status is sticky and cleared by writing one; new events win
  wire [`LPRC_IRQ_W-1:0] irq_events = {evt.cap_done, evt.set_done, missing, evt.alarm_hit};
  wire [`LPRC_IRQ_W-1:0] irq_clear = wr_irq_stat ? i_wr_data[`LPRC_IRQ_W-1:0] : '0;
  assign irq_stat_next = irq_events | (irq_stat_reg & ~irq_clear);
  assign irq_mask_next = wr_irq_mask ? i_wr_data[`LPRC_IRQ_W-1:0] : irq_mask_reg;

  // Read view of the control register
  wire [7:0] ctrl_view = {
    osc_en_reg,
    mclk_en_reg,
    fail_reg,
    run_reg,
    aen_reg,
    alarm_flag_reg,
    set_pend_reg,
    cap_pend_reg
  };
  wire [7:0] stat_view = {6'h00, load_cap_ready, clock_valid};

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_data_next = 8'h00;
    if (i_rd_en) begin
      if (i_addr == `LPRC_ADDR_CFG) begin
        rd_data_next = cfg_reg;
      end else if (i_addr == `LPRC_ADDR_LOADCAP) begin
        rd_data_next = loadcap_reg;
      end else if (i_addr == `LPRC_ADDR_STAT) begin
        rd_data_next = stat_view;
      end else if (i_addr == `LPRC_ADDR_CTRL) begin
        rd_data_next = ctrl_view;
      end else if (in_tdata) begin
        rd_data_next = byte_of(capture, byte_idx);
      end else if (in_alarm) begin
        rd_data_next = byte_of(alarm_val_reg, byte_idx);
      end else if (i_addr == `LPRC_ADDR_IRQ_STAT) begin
        rd_data_next = 8'(irq_stat_reg);
      end else if (i_addr == `LPRC_ADDR_IRQ_MASK) begin
        rd_data_next = 8'(irq_mask_reg);
      end
    end
  end

  // Configuration state
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cfg_reg <= lprc_pkg::lprc_osc_cfg_s'(`LPRC_CFG_RESET);
      loadcap_reg <= `LPRC_LOADCAP_RESET;
      settle_reg <= LW'(LOADCAP_CYCLES);
      load_reg <= '0;
      alarm_val_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      loadcap_reg <= loadcap_next;
      settle_reg <= settle_next;
      load_reg <= load_next;
      alarm_val_reg <= alarm_val_next;
    end
  end

  // Control bits
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      osc_en_reg <= 1'b0;
      mclk_en_reg <= 1'b0;
      fail_reg <= 1'b0;
      run_reg <= 1'b0;
      aen_reg <= 1'b0;
      autoreset_reg <= 1'b0;
      alarm_flag_reg <= 1'b0;
      set_pend_reg <= 1'b0;
      cap_pend_reg <= 1'b0;
    end else begin
      osc_en_reg <= osc_en_next;
      mclk_en_reg <= mclk_en_next;
      fail_reg <= fail_next;
      run_reg <= run_next;
      aen_reg <= aen_next;
      autoreset_reg <= autoreset_next;
      alarm_flag_reg <= alarm_flag_next;
      set_pend_reg <= set_pend_next;
      cap_pend_reg <= cap_pend_next;
    end
  end

  // Interrupts and read data
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      o_rd_data <= 8'h00;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      o_rd_data <= rd_data_next;
    end
  end

  // Analog controls; bias and gain only reach the oscillator while it is powered
  assign o_osc_power_enable = osc_en_reg;
  assign o_crystal_mode_select = cfg_reg.crystal_mode_select;
  assign o_gain_control_enable = osc_en_reg & cfg_reg.gain_control_enable;
  assign o_bias_double = osc_en_reg & cfg_reg.bias_double;
  assign o_load_cap_config = loadcap_reg;
  // Trim only matters in self-oscillate mode, where it sets the 10 to 40 kHz rate
  assign o_self_osc_trim = cfg_reg.crystal_mode_select ? 4'h0 : cfg_reg.self_osc_trim;
  assign o_low_freq_internal_osc_enable = osc_en_reg & cfg_reg.lfo_select;
  assign o_alarm_flag = alarm_flag_reg;
  assign o_irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// *** lprc_rtc_ctrl_checker.sv ***
// Port-level assertions for the low-power clock control block
`timescale 1ns/1ps
module lprc_rtc_ctrl_checker (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic i_crystal_in_pin,
  input wire logic i_low_freq_internal_osc,
  input wire logic o_osc_power_enable,
  input wire logic o_crystal_mode_select,
  input wire logic o_gain_control_enable,
  input wire logic o_bias_double,
  input wire logic [7:0] o_load_cap_config,
  input wire logic [3:0] o_self_osc_trim,
  input wire logic o_low_freq_internal_osc_enable,
  input wire logic o_alarm_flag,
  input wire logic o_irq
);
  // Bound suits the fast bench timebase only; a real 32 kHz tick needs a counter
  localparam int ALARM_MAX = 64;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence s_ctrl_wr;
    i_wr_en && i_addr == 8'h04;
  endsequence
  sequence s_cfg_wr;
    i_wr_en && i_addr == 8'h00;
  endsequence
  property p_rd_idle; !i_rd_en |=> o_rd_data == 8'h00; endproperty
  property p_pwr_wr; s_ctrl_wr |=> o_osc_power_enable == $past(i_wr_data[7]); endproperty
  property p_pwr_hold; !(i_wr_en && i_addr == 8'h04) |=> $stable(o_osc_power_enable); endproperty
  property p_bias_pwr; (o_gain_control_enable || o_bias_double) |-> o_osc_power_enable; endproperty
  property p_lfo_pwr; o_low_freq_internal_osc_enable |-> o_osc_power_enable; endproperty
  property p_trim_xtal; o_crystal_mode_select |-> o_self_osc_trim == 4'h0; endproperty
  property p_cfg_wr;
    s_cfg_wr |=> o_crystal_mode_select == $past(i_wr_data[0]) &&
      o_self_osc_trim == ($past(i_wr_data[0]) ? 4'h0 : $past(i_wr_data[7:4]));
  endproperty
  property p_lcap_wr; i_wr_en && i_addr == 8'h01 |=> o_load_cap_config == $past(i_wr_data); endproperty
  property p_alarm_short; $rose(o_alarm_flag) |-> ##[1:ALARM_MAX] !o_alarm_flag; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  a_pwr_wr: assert property (p_pwr_wr) else $error("power enable not written");
  a_pwr_hold: assert property (p_pwr_hold) else $error("power enable changed alone");
  a_bias_pwr: assert property (p_bias_pwr) else $error("bias active while unpowered");
  a_lfo_pwr: assert property (p_lfo_pwr) else $error("internal osc on while unpowered");
  a_trim_xtal: assert property (p_trim_xtal) else $error("trim active in crystal mode");
  a_cfg_wr: assert property (p_cfg_wr) else $error("mode or trim not written");
  a_lcap_wr: assert property (p_lcap_wr) else $error("load capacitance not written");
  a_alarm_short: assert property (p_alarm_short) else $error("alarm flag held too long");
endmodule

// *** lprc_xtal_model.sv ***
// Behavioural watch crystal or CMOS clock source on the timebase pin
`timescale 1ns/1ps
module lprc_xtal_model #(
  parameter int HALF_NS = 46
) (
  input wire logic i_powered,
  input wire logic i_present,
  output logic o_pin
);
  // Scaled far above 32.768 kHz to keep the run short; not a multiple of the system clock
  initial o_pin = 1'b0;
  always begin
    #HALF_NS;
    if (i_powered && i_present) begin
      o_pin = ~o_pin;
    end
  end
endmodule

// *** tb_lprc_rtc_ctrl.sv ***
// Self-checking testbench of the low-power clock control block
`timescale 1ns/1ps
`include "lprc_defines.svh"
module tb_lprc_rtc_ctrl;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_low_freq_internal_osc = 1'b0;
  logic xtal_ok = 1'b1;
  logic xtal_pin;
  logic [7:0] o_rd_data;
  logic o_osc_power_enable, o_crystal_mode_select, o_gain_control_enable, o_bias_double;
  logic [7:0] o_load_cap_config;
  logic [3:0] o_self_osc_trim;
  logic o_low_freq_internal_osc_enable, o_alarm_flag, o_irq;
  logic [31:0] cap_a, cap_b;
  logic [7:0] d;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  // Internal oscillator only runs while the block enables it; even half periods keep pin edges off rising clock edges
  always #62 if (o_low_freq_internal_osc_enable) i_low_freq_internal_osc = ~i_low_freq_internal_osc;
  lprc_rtc_ctrl #(.TIMER_W(32), .MISS_CYCLES(50), .LOADCAP_CYCLES(20)) uut (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_crystal_in_pin(xtal_pin),
    .i_low_freq_internal_osc(i_low_freq_internal_osc), .o_osc_power_enable(o_osc_power_enable),
    .o_crystal_mode_select(o_crystal_mode_select), .o_gain_control_enable(o_gain_control_enable),
    .o_bias_double(o_bias_double), .o_load_cap_config(o_load_cap_config), .o_self_osc_trim(o_self_osc_trim),
    .o_low_freq_internal_osc_enable(o_low_freq_internal_osc_enable), .o_alarm_flag(o_alarm_flag), .o_irq(o_irq));
  lprc_xtal_model #(.HALF_NS(46)) u_xtal (.i_powered(o_osc_power_enable), .i_present(xtal_ok), .o_pin(xtal_pin));
  // Whole run needs about a thousand cycles
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_en <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    #1;
    v = o_rd_data;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      wr(a + 8'(i), v[8*i +: 8]);
    end
  endtask
  task automatic rd32(output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      rd(`LPRC_ADDR_TDATA0 + 8'(i), b);
      v[8*i +: 8] = b;
    end
  endtask
  // Bounded poll of one register bit; a timeout shows up as a mismatch
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    logic [7:0] r;
    int n;
    n = 0;
    rd(a, r);
    while (r[b] !== v && n < 150) begin
      rd(a, r);
      n++;
    end
    chk(r[b], v);
  endtask
  task automatic wflag();
    int n;
    n = 0;
    // A flag still standing from the last hit must fall first
    while (o_alarm_flag === 1'b1 && n < 300) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    while (o_alarm_flag !== 1'b1 && n < 300) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk(o_alarm_flag, 1'b1);
  endtask
  task automatic t_reset();
    logic [7:0] a [6] = '{8'h00, 8'h01, 8'h04, 8'h10, 8'h11, 8'h20};
    for (int i = 0; i < 6; i++) begin
      rd(a[i], d);
      chk(d, 8'h00);
    end
    chk(o_osc_power_enable, 1'b0);
    $display("reset values done");
  endtask
  task automatic t_startup();
    wr(`LPRC_ADDR_CFG, 8'h05);
    wr(`LPRC_ADDR_LOADCAP, 8'h5a);
    chk({o_load_cap_config, o_bias_double}, {8'h5a, 1'b0});
    wr(`LPRC_ADDR_CTRL, 8'h80);
    chk({o_osc_power_enable, o_crystal_mode_select, o_gain_control_enable, o_bias_double}, 4'hd);
    poll(`LPRC_ADDR_STAT, 0, 1'b1);
    poll(`LPRC_ADDR_STAT, 1, 1'b1);
    wr(`LPRC_ADDR_CFG, 8'h03);
    chk({o_gain_control_enable, o_bias_double}, 2'b10);
    wr(`LPRC_ADDR_CTRL, 8'hc0);
    $display("startup done");
  endtask
  task automatic t_timer();
    wr32(`LPRC_ADDR_TDATA0, 32'h0000_0010);
    wr(`LPRC_ADDR_CTRL, 8'hc2);
    poll(`LPRC_ADDR_CTRL, 1, 1'b0);
    wr(`LPRC_ADDR_CTRL, 8'hc1);
    poll(`LPRC_ADDR_CTRL, 0, 1'b0);
    rd32(cap_a);
    chk(cap_a, 32'h0000_0010);
    rd(`LPRC_ADDR_IRQ_STAT, d);
    chk(d[3:2], 2'b11);
    wr(`LPRC_ADDR_CTRL, 8'hd0);
    repeat (100) @(posedge i_sys_clk);
    wr(`LPRC_ADDR_CTRL, 8'hc1);
    poll(`LPRC_ADDR_CTRL, 0, 1'b0);
    rd32(cap_a);
    repeat (60) @(posedge i_sys_clk);
    wr(`LPRC_ADDR_CTRL, 8'hc1);
    poll(`LPRC_ADDR_CTRL, 0, 1'b0);
    rd32(cap_b);
    chk(cap_b, cap_a);
    chk(cap_a > 32'h0000_0014, 1'b1);
    $display("timer done");
  endtask
  task automatic t_alarm();
    wr32(`LPRC_ADDR_ALARM0, 32'h0000_0005);
    wr32(`LPRC_ADDR_TDATA0, 32'h0000_0000);
    wr(`LPRC_ADDR_IRQ_MASK, 8'h01);
    wr(`LPRC_ADDR_CTRL, 8'hde);
    wflag();
    rd(`LPRC_ADDR_CTRL, d);
    chk({d[2], o_irq}, 2'b11);
    wflag();
    wr(`LPRC_ADDR_CTRL, 8'hdc);
    chk(o_alarm_flag, 1'b0);
    wr(`LPRC_ADDR_IRQ_STAT, 8'h01);
    chk(o_irq, 1'b0);
    wr(`LPRC_ADDR_IRQ_MASK, 8'h00);
    wflag();
    chk(o_irq, 1'b0);
    // Alarm off with auto-reset on: a write to the flag bit must not raise it
    wr(`LPRC_ADDR_CTRL, 8'hc4);
    repeat (30) @(posedge i_sys_clk);
    chk(o_alarm_flag, 1'b0);
    $display("alarm done");
  endtask
  task automatic t_fail();
    wr(`LPRC_ADDR_CTRL, 8'hc0);
    xtal_ok = 1'b0;
    poll(`LPRC_ADDR_CTRL, 5, 1'b1);
    rd(`LPRC_ADDR_IRQ_STAT, d);
    chk(d[1], 1'b1);
    poll(`LPRC_ADDR_STAT, 0, 1'b0);
    wr(`LPRC_ADDR_CTRL, 8'he0);
    rd(`LPRC_ADDR_CTRL, d);
    chk(d[5], 1'b1);
    xtal_ok = 1'b1;
    poll(`LPRC_ADDR_STAT, 0, 1'b1);
    wr(`LPRC_ADDR_CTRL, 8'hc0);
    rd(`LPRC_ADDR_CTRL, d);
    chk(d[5], 1'b0);
    $display("failure detect done");
  endtask
  task automatic t_power();
    wr(`LPRC_ADDR_CFG, 8'ha8);
    chk({o_crystal_mode_select, o_self_osc_trim, o_low_freq_internal_osc_enable}, 6'h15);
    wr(`LPRC_ADDR_CTRL, 8'h00);
    chk({o_osc_power_enable, o_gain_control_enable, o_bias_double, o_low_freq_internal_osc_enable}, 4'h0);
    poll(`LPRC_ADDR_STAT, 0, 1'b0);
    // Crystal absent, so only the internal oscillator can make the clock valid
    xtal_ok = 1'b0;
    wr(`LPRC_ADDR_CTRL, 8'h80);
    poll(`LPRC_ADDR_STAT, 0, 1'b1);
    wr(`LPRC_ADDR_CTRL, 8'h00);
    $display("power off done");
  endtask
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_reset();
    t_startup();
    t_timer();
    t_alarm();
    t_fail();
    t_power();
    complete_run();
  end
endmodule
bind lprc_rtc_ctrl lprc_rtc_ctrl_checker u_chk (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_crystal_in_pin(i_crystal_in_pin),
  .i_low_freq_internal_osc(i_low_freq_internal_osc), .o_osc_power_enable(o_osc_power_enable),
  .o_crystal_mode_select(o_crystal_mode_select), .o_gain_control_enable(o_gain_control_enable),
  .o_bias_double(o_bias_double), .o_load_cap_config(o_load_cap_config), .o_self_osc_trim(o_self_osc_trim),
  .o_low_freq_internal_osc_enable(o_low_freq_internal_osc_enable), .o_alarm_flag(o_alarm_flag), .o_irq(o_irq));
